// *** verilog/serial_port_consts.vh ***
/*
 * constants for the asynchronous serial port: control bit positions,
 * reset values, clock divider ratios and timing figures.
 * assumes inclusion by bare name from the design file.
 */
// Operation
// R1 - full duplex asynchronous port, 8-bit and 9-bit variable-rate frames.
// R2 - receive latch holds one byte while the next shifts in.
// R3 - data writes go to transmit register; reads return receive latch only.
// R4 - interrupt request while enabled whenever tx-done or rx-done flag is set.
// R5 - hardware never clears the done flags; software clears them.
// R6 - bit clock from 8-bit auto-reload baud timer; tx uses its overflows.
// R7 - hidden receive timer runs with baud timer, same reload byte.
// R8 - tx and rx timer overflows each divided by two.
// R9 - start edge on serial input forces immediate receive timer reload.
// R10 - bit rate is timer clock over (256 minus reload), halved.
// R11 - timer clock: system clock /4, /12, /48, external /8, or pin.
// R12 - software sets auto-reload and a reload for twice the bit rate.
// R13 - control bit 7 selects 8-bit or 9-bit frame format.
// R14 - 8-bit frame: start, eight data bits LSB first, stop.
// R15 - shift out LSB first on output pin, sample input pin.
// R16 - writing the data buffer starts a transmission; the port ignores a write while a frame is in progress.
// R17 - tx-done flag, control bit 1, set when stop-bit time begins.
// R18 - receiver accepts characters only while control bit 4 is set.
// R19 - accept if rx-done clear and stop ok; latch data, stop bit, flag.
// R20 - on failed acceptance nothing is loaded and no flag is set.
// R21 - on overrun the latch keeps the first byte; later data is lost.
// R22 - line idles high; start low, stop high, start found on falling edge.
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

// control register bit positions
`define CTL_MODE_BIT      7
`define CTL_UNUSED_BIT    6
`define CTL_STOPCHK_BIT   5
`define CTL_RXEN_BIT      4
`define CTL_TXB9_BIT      3
`define CTL_RXB9_BIT      2
`define CTL_TXDONE_BIT    1
`define CTL_RXDONE_BIT    0
`define CTL_RESET         8'h40
`define DATA_RESET        8'h00

// baud timer clock selections
`define CLKSEL_DIV4       3'h0
`define CLKSEL_DIV12      3'h1
`define CLKSEL_DIV48      3'h2
`define CLKSEL_EXT8       3'h3
`define CLKSEL_PIN        3'h4
`define PRESCALE_W        6
`define DIV4_LAST         6'h03
`define DIV12_LAST        6'h0B
`define DIV48_LAST        6'h2F
`define EXT8_LAST         3'h7

// receive sampling: middle of the bit is one timer overflow after the edge
`define RX_BITS_LAST      4'h9
`define TX_BITS_LAST      4'h9

`endif

// *** verilog/serial_port.v ***
/*
 * asynchronous serial port with 8-bit and 9-bit frames, a shared data
 * buffer location, done flags cleared by software and an 8-bit
 * auto-reload baud timer with a hidden receive copy.
 * assumes one 200 MHz clock; serial input, external oscillator and
 * timer pin are asynchronous and pass two flip-flops first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_consts.vh"

module serial_port (
    // clock, reset, enable
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       clk_en,
    // control register access
    input  wire       ctl_wr,
    input  wire [7:0] ctl_wdata,
    output wire [7:0] serial_control_reg,
    // data buffer access
    input  wire       data_wr,
    input  wire [7:0] data_wdata,
    output wire [7:0] serial_data_buffer,
    // baud timer setup
    input  wire       timer_run,
    input  wire [2:0] timer_clk_sel,
    input  wire [7:0] baud_reload_byte,
    output wire [7:0] baud_timer_low,
    // external timer clocks
    input  wire       ext_osc_in,
    input  wire       timer_ext_input,
    // interrupt
    input  wire       irq_enable,
    output wire       irq,
    // serial pins
    input  wire       serial_in_pin,
    output wire       serial_out_pin
);

    // ==========================================================
    // input synchronisers
    // ==========================================================
    reg [2:0] sync1_ff;
    reg [2:0] sync2_ff;
    reg       rx_prev_ff;
    reg       osc_prev_ff;
    reg       pin_prev_ff;

    // two flops per asynchronous input, edge history after the second
    always @(posedge clk) begin
        if (sys_rst) begin
            sync1_ff    <= 3'h1;                                 // idle levels: no false edge
            sync2_ff    <= 3'h1;
            rx_prev_ff  <= 1'b1;
            osc_prev_ff <= 1'b0;
            pin_prev_ff <= 1'b0;
        end else if (clk_en) begin
            sync1_ff    <= {timer_ext_input, ext_osc_in, serial_in_pin};
            sync2_ff    <= sync1_ff;
            rx_prev_ff  <= sync2_ff[0];
            osc_prev_ff <= sync2_ff[1];
            pin_prev_ff <= sync2_ff[2];
        end
    end

    wire rx_line  = sync2_ff[0];
    wire osc_rise = sync2_ff[1] & ~osc_prev_ff;
    wire pin_rise = sync2_ff[2] & ~pin_prev_ff;

    // ==========================================================
    // baud timer clock selection
    // ==========================================================
    reg [`PRESCALE_W-1:0] pre_ff;
    reg [2:0]             ext_div_ff;

    // prescale limit for the selected system clock divider
    function [`PRESCALE_W-1:0] pre_last;
        input [2:0] sel;
        begin
            case (sel)
                `CLKSEL_DIV4:  pre_last = `DIV4_LAST;
                `CLKSEL_DIV12: pre_last = `DIV12_LAST;
                default:       pre_last = `DIV48_LAST;
            endcase
        end
    endfunction

    // wrap at or past the limit so a switch to a smaller divider recovers at once
    wire pre_wrap = (pre_ff >= pre_last(timer_clk_sel));
    wire ext_wrap = osc_rise && (ext_div_ff == `EXT8_LAST);
    reg  timer_tick;

    // pick one of the five timer clock sources [R11]
    always @* begin
        case (timer_clk_sel)
            `CLKSEL_DIV4, `CLKSEL_DIV12, `CLKSEL_DIV48: timer_tick = pre_wrap;
            `CLKSEL_EXT8: timer_tick = ext_wrap;
            `CLKSEL_PIN:  timer_tick = pin_rise;
            default:      timer_tick = 1'b0;
        endcase
    end

    // prescalers
    always @(posedge clk) begin
        if (sys_rst) begin
            pre_ff     <= {`PRESCALE_W{1'b0}};
            ext_div_ff <= 3'h0;
        end else if (clk_en) begin
            pre_ff <= pre_wrap ? {`PRESCALE_W{1'b0}} : pre_ff + 1'b1;
            if (osc_rise)
                ext_div_ff <= ext_div_ff + 1'b1;                 // [R11]
        end
    end

    // ==========================================================
    // transmit timer and hidden receive timer
    // ==========================================================
    reg [7:0] tx_tmr_ff;
    reg [7:0] rx_tmr_ff;
    reg       tx_half_ff;
    reg       rx_half_ff;
    reg       rx_start_req;

    wire tx_ovf = timer_run && timer_tick && (tx_tmr_ff == 8'hFF);
    wire rx_ovf = timer_run && timer_tick && (rx_tmr_ff == 8'hFF) && !rx_start_req;
    wire tx_bit_tick = tx_ovf && tx_half_ff;                     // [R8]
    wire rx_bit_tick = rx_ovf && rx_half_ff;                     // [R8]
    wire rx_mid_tick = rx_ovf && !rx_half_ff;

    assign baud_timer_low = tx_tmr_ff;

    // 8-bit auto-reload counters; rate = timer_tick rate/(256-reload)/2 [R6] [R10]
    always @(posedge clk) begin
        if (sys_rst) begin
            tx_tmr_ff  <= 8'h00;
            rx_tmr_ff  <= 8'h00;
            tx_half_ff <= 1'b0;
            rx_half_ff <= 1'b0;
        end else if (clk_en) begin
            if (timer_run && timer_tick) begin
                tx_tmr_ff <= tx_ovf ? baud_reload_byte : tx_tmr_ff + 1'b1;  // [R6]
                if (tx_ovf)
                    tx_half_ff <= ~tx_half_ff;
            end
            if (rx_start_req) begin
                rx_tmr_ff  <= baud_reload_byte;                  // [R9]
                rx_half_ff <= 1'b0;
            end else if (timer_run && timer_tick) begin
                rx_tmr_ff <= rx_ovf ? baud_reload_byte : rx_tmr_ff + 1'b1;  // [R7]
                if (rx_ovf)
                    rx_half_ff <= ~rx_half_ff;
            end
        end
    end

    // ==========================================================
    // control flags and data latch
    // ==========================================================
    reg       mode_ff;
    reg       stopchk_ff;
    reg       rxen_ff;
    reg       txb9_ff;
    reg       rxb9_ff;
    reg       txdone_ff;
    reg       rxdone_ff;
    reg [7:0] rx_latch_ff;
    wire      tx_done_set;
    wire      rx_accept;
    wire [7:0] rx_data;
    wire      rx_bit9;
    wire [7:0] ctl_reset_val = `CTL_RESET;

    assign serial_control_reg = {mode_ff, 1'b1, stopchk_ff, rxen_ff,
                                 txb9_ff, rxb9_ff, txdone_ff, rxdone_ff};
    assign serial_data_buffer = rx_latch_ff;                     // [R3]
    assign irq = irq_enable & (txdone_ff | rxdone_ff);           // [R4]

    // software writes; hardware sets win over a clear in the same cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            mode_ff     <= ctl_reset_val[`CTL_MODE_BIT];
            stopchk_ff  <= 1'b0;
            rxen_ff     <= 1'b0;
            txb9_ff     <= 1'b0;
            rxb9_ff     <= 1'b0;
            txdone_ff   <= 1'b0;
            rxdone_ff   <= 1'b0;
            rx_latch_ff <= `DATA_RESET;
        end else if (clk_en) begin
            if (ctl_wr) begin
                mode_ff    <= ctl_wdata[`CTL_MODE_BIT];          // [R13]
                stopchk_ff <= ctl_wdata[`CTL_STOPCHK_BIT];
                rxen_ff    <= ctl_wdata[`CTL_RXEN_BIT];
                txb9_ff    <= ctl_wdata[`CTL_TXB9_BIT];
                rxb9_ff    <= ctl_wdata[`CTL_RXB9_BIT];
                txdone_ff  <= ctl_wdata[`CTL_TXDONE_BIT];        // [R5]
                rxdone_ff  <= ctl_wdata[`CTL_RXDONE_BIT];        // [R5]
            end
            if (tx_done_set)
                txdone_ff <= 1'b1;                               // [R17]
            if (rx_accept) begin
                rx_latch_ff <= rx_data;                          // [R2] [R19]
                rxb9_ff     <= rx_bit9;                          // [R19]
                rxdone_ff   <= 1'b1;                             // [R19]
            end
        end
    end

    // ==========================================================
    // transmitter
    // ==========================================================
    reg       tx_busy_ff;
    reg [3:0] tx_cnt_ff;
    reg [9:0] tx_shift_ff;
    reg       tx_out_ff;

    // stop bit position: count 9 in 8-bit mode, count 10 in 9-bit mode
    wire [3:0] tx_stop_pos = mode_ff ? 4'hA : `TX_BITS_LAST;
    // flag rises with the tick that drives the stop level [R17]
    assign tx_done_set = tx_busy_ff && tx_bit_tick && (tx_cnt_ff == tx_stop_pos);
    assign serial_out_pin = tx_out_ff;

    // load on data write, shift LSB first each bit time [R14] [R15] [R16]
    always @(posedge clk) begin
        if (sys_rst) begin
            tx_busy_ff  <= 1'b0;
            tx_cnt_ff   <= 4'h0;
            tx_shift_ff <= 10'h3FF;
            tx_out_ff   <= 1'b1;                                 // [R22]
        end else if (clk_en) begin
            if (data_wr && !tx_busy_ff) begin
                tx_shift_ff <= {1'b1, txb9_ff, data_wdata};      // [R16]
                tx_busy_ff  <= 1'b1;
                tx_cnt_ff   <= 4'h0;
            end else if (tx_busy_ff && tx_bit_tick) begin
                if (tx_cnt_ff == 4'h0) begin
                    tx_out_ff <= 1'b0;                           // [R22]
                end else if (tx_cnt_ff == tx_stop_pos) begin
                    tx_out_ff <= 1'b1;                           // [R14]
                end else begin
                    tx_out_ff   <= tx_shift_ff[0];               // [R15]
                    tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
                end
                if (tx_cnt_ff == tx_stop_pos + 4'h1) begin
                    tx_busy_ff <= 1'b0;
                    tx_out_ff  <= 1'b1;
                end
                tx_cnt_ff <= tx_cnt_ff + 4'h1;
            end
        end
    end

    // ==========================================================
    // receiver
    // ==========================================================
    localparam RX_IDLE = 2'h0;
    localparam RX_BITS = 2'h1;
    reg [1:0] rx_st_ff;
    reg [3:0] rx_cnt_ff;
    reg [7:0] rx_shift_ff;
    reg       rx_b9_ff;

    wire [3:0] rx_stop_pos = mode_ff ? 4'hA : `RX_BITS_LAST;
    wire       rx_fall = rx_prev_ff & ~rx_line;                  // [R22]

    // start edge request while enabled and idle [R18]
    always @* begin
        rx_start_req = (rx_st_ff == RX_IDLE) && rxen_ff && rx_fall && timer_run;  // [R9]
    end

    wire rx_stop_now = (rx_st_ff == RX_BITS) && rx_mid_tick && (rx_cnt_ff == rx_stop_pos);
    assign rx_data = rx_shift_ff;
    // 8-bit mode stores the stop bit, 9-bit mode the ninth data bit
    assign rx_bit9 = mode_ff ? rx_b9_ff : rx_line;
    assign rx_accept = rx_stop_now && !rxdone_ff &&               // [R20] [R21]
                       (!stopchk_ff || (mode_ff ? rx_b9_ff : rx_line));  // [R19]

    // sample mid-bit on every other receive overflow [R1]
    always @(posedge clk) begin
        if (sys_rst) begin
            rx_st_ff    <= RX_IDLE;
            rx_cnt_ff   <= 4'h0;
            rx_shift_ff <= 8'h00;
            rx_b9_ff    <= 1'b0;
        end else if (clk_en) begin
            case (rx_st_ff)
                RX_IDLE: begin
                    if (rx_start_req) begin
                        rx_st_ff  <= RX_BITS;
                        rx_cnt_ff <= 4'h0;
                    end
                end
                RX_BITS: begin
                    if (rx_mid_tick) begin
                        if (rx_cnt_ff == 4'h0 && rx_line) begin
                            rx_st_ff <= RX_IDLE;                 // false start
                        end else if (rx_cnt_ff == rx_stop_pos) begin
                            rx_st_ff <= RX_IDLE;
                        end else if (rx_cnt_ff != 4'h0) begin
                            if (mode_ff && rx_cnt_ff == 4'h9)
                                rx_b9_ff <= rx_line;
                            else
                                rx_shift_ff <= {rx_line, rx_shift_ff[7:1]};  // [R15]
                        end
                        rx_cnt_ff <= rx_cnt_ff + 4'h1;
                    end
                end
                default: rx_st_ff <= RX_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// *** verification/serial_port_chk.sv ***
/*
 * concurrent checks on the serial port's top-level ports.
 * assumes one clock, synchronous active-high reset held several cycles.
 */
`timescale 1ns/10ps
`default_nettype none
// ==================================================================
// port checker
module serial_port_chk (
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // control and data buffer
    input wire logic       ctl_wr,
    input wire logic [7:0] ctl_wdata,
    input wire logic [7:0] serial_control_reg,
    input wire logic [7:0] serial_data_buffer,
    // interrupt and serial output
    input wire logic       irq_enable,
    input wire logic       irq,
    input wire logic       serial_out_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // hardware setting the receive flag, not a software write
    sequence s_hw_rx_set;
        $rose(serial_control_reg[0]) && !$past(ctl_wr);
    endsequence
    // a start bit lasts at least eight clocks, the shortest bit time from a system clock divider
    sequence s_start_low;
        !serial_out_pin [*8];
    endsequence
    a_reset_state: assert property (disable iff (1'b0) sys_rst |=>
        serial_control_reg == 8'h40 && serial_data_buffer == 8'h00 && serial_out_pin)
        else $error("reset state wrong");
    a_irq_flags: assert property (irq == (irq_enable && serial_control_reg[1:0] != 2'h0))
        else $error("irq does not follow flags");
    a_ctl_write: assert property (ctl_wr |=>
        {serial_control_reg[7], serial_control_reg[5:3]} == $past({ctl_wdata[7], ctl_wdata[5:3]}))
        else $error("control write lost");
    a_flags_sticky: assert property (($fell(serial_control_reg[1]) ||
        $fell(serial_control_reg[0])) && !$past(sys_rst) |-> $past(ctl_wr))
        else $error("flag cleared by hardware");
    a_txdone_stop: assert property ($rose(serial_control_reg[1]) && !$past(ctl_wr)
        |-> serial_out_pin) else $error("tx done not at stop bit");
    a_rx_needs_en: assert property (s_hw_rx_set |-> $past(serial_control_reg[4]))
        else $error("receive while disabled");
    a_buf_with_flag: assert property (!$stable(serial_data_buffer) && !$past(sys_rst)
        |-> $rose(serial_control_reg[0])) else $error("buffer changed without flag");
    a_stop_checked: assert property (s_hw_rx_set ##0
        (!serial_control_reg[7] && serial_control_reg[5]) |-> serial_control_reg[2])
        else $error("bad stop accepted");
    a_start_len: assert property ($fell(serial_out_pin) |-> s_start_low)
        else $error("start bit too short");
endmodule
bind serial_port serial_port_chk i_chk (.clk(clk), .sys_rst(sys_rst), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .serial_control_reg(serial_control_reg),
    .serial_data_buffer(serial_data_buffer), .irq_enable(irq_enable), .irq(irq),
    .serial_out_pin(serial_out_pin));
`default_nettype wire

// *** verification/serial_peer.sv ***
/*
 * behavioural far-end serial transceiver: sends and receives 8-bit frames.
 * assumes the bench sets bit_clks to the bit time in clock cycles.
 */
`timescale 1ns/10ps
`default_nettype none
// ==================================================================
// remote transceiver
module serial_peer (
    // clock
    input  wire logic clk,
    // serial lines seen from the peer
    input  wire logic rx_line,
    output logic      tx_line
);
    int         bit_clks  = 16;
    logic [7:0] got_byte  = 8'h00;
    int         got_count = 0;
    // line idles high between frames
    initial tx_line = 1'b1;
    // start low, data lsb first, chosen stop level, then idle high
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] frame;
        frame = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk) tx_line = frame[i];
            repeat (bit_clks - 1) @(negedge clk);
        end
        @(negedge clk) tx_line = 1'b1;
    endtask
    // receive on falling edge, sample mid bit, count only with a high stop
    always begin
        @(negedge rx_line);
        repeat (bit_clks / 2) @(posedge clk);
        if (rx_line === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (bit_clks) @(posedge clk);
                got_byte[i] = rx_line;
            end
            repeat (bit_clks) @(posedge clk);
            if (rx_line === 1'b1) got_count++;
        end
    end
endmodule
`default_nettype wire

// *** verification/serial_port_tb.sv ***
/*
 * self-checking bench: transmit at three prescaler settings, receive paths.
 * assumes the serial port design and the behavioural peer.
 */
`timescale 1ns/10ps
`default_nettype none
// ==================================================================
// bench
module serial_port_tb;
    logic       clk        = 1'b0;
    logic       sys_rst    = 1'b1;
    logic       ctl_wr     = 1'b0;
    logic [7:0] ctl_wdata  = 8'h00;
    logic       data_wr    = 1'b0;
    logic [7:0] data_wdata = 8'h00;
    logic       timer_run  = 1'b0;
    logic [2:0] timer_clk_sel = 3'h0;
    logic [7:0] reload     = 8'hFE;
    logic       irq_enable = 1'b0;
    logic       ext_osc    = 1'b0;
    logic       ext_pin    = 1'b0;
    wire logic       rx_wire, tx_wire, irq;
    wire logic [7:0] ctl, rx_buf, tmr_low;
    int         failures   = 0;
    int         num_checks = 0;
    int         n0, bit_len;
    int         divs [3]   = '{4, 12, 48};
    logic [7:0] tx_bytes [3] = '{8'hA5, 8'h3C, 8'h81};
    always #2.5 clk = ~clk;
    serial_port i_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .ctl_wr(ctl_wr),
        .ctl_wdata(ctl_wdata), .serial_control_reg(ctl), .data_wr(data_wr),
        .data_wdata(data_wdata), .serial_data_buffer(rx_buf), .timer_run(timer_run),
        .timer_clk_sel(timer_clk_sel), .baud_reload_byte(reload), .baud_timer_low(tmr_low),
        .ext_osc_in(ext_osc), .timer_ext_input(ext_pin), .irq_enable(irq_enable), .irq(irq),
        .serial_in_pin(rx_wire), .serial_out_pin(tx_wire));
    serial_peer i_peer (.clk(clk), .rx_line(tx_wire), .tx_line(rx_wire));
    // compare one value, count it, report a difference
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write pulse to control or data buffer
    task automatic wr(input logic to_data, input logic [7:0] v);
        @(negedge clk);
        ctl_wr = !to_data;
        data_wr = to_data;
        ctl_wdata = v;
        data_wdata = v;
        @(negedge clk);
        ctl_wr = 1'b0;
        data_wr = 1'b0;
    endtask
    // bounded wait for a control flag
    task automatic wait_flag(input int idx);
        for (int n = 0; n < 4000 && ctl[idx] !== 1'b1; n++) @(posedge clk);
        @(negedge clk);
        chk("flag wait", 8'h01, {7'h00, ctl[idx]});
    endtask
    // n slow rising edges on the timer pin (pin=1) or the oscillator (pin=0)
    task automatic pulse(input logic pin, input int n);
        repeat (n) begin
            {ext_pin, ext_osc} = pin ? 2'b10 : 2'b01;
            repeat (2) @(negedge clk);
            {ext_pin, ext_osc} = 2'b00;
            repeat (2) @(negedge clk);
        end
        repeat (4) @(negedge clk);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        chk("control", 8'h40, ctl);
        chk("rx buffer", 8'h00, rx_buf);
        chk("idle pin", 8'h01, {7'h00, tx_wire});
        wr(0, 8'h38);
        chk("control", 8'h78, ctl);
        $display("test reset done");
        timer_run = 1'b1;
        irq_enable = 1'b1;
        for (int k = 0; k < 3; k++) begin
            timer_clk_sel = 3'(k);
            reload = (k == 0) ? 8'hFE : 8'hFF;
            bit_len = 2 * (256 - reload) * divs[k];
            i_peer.bit_clks = bit_len;
            wr(0, 8'h00);
            n0 = i_peer.got_count;
            wr(1, tx_bytes[k]);
            wr(1, ~tx_bytes[k]);
            wait_flag(1);
            repeat (2 * bit_len) @(negedge clk);
            chk("irq", 8'h01, {7'h00, irq});
            chk("tx byte", tx_bytes[k], i_peer.got_byte);
            wr(0, 8'h00);
            chk("irq", 8'h00, {7'h00, irq});
            repeat (12 * bit_len) @(negedge clk);
            chk("tx count", 8'h01, 8'(i_peer.got_count - n0));
            chk("control", 8'h40, ctl);
        end
        $display("test transmit done");
        chk("timer low", 8'hFF, tmr_low);
        timer_clk_sel = 3'h4;
        reload = 8'hF0;
        pulse(1'b1, 3);
        chk("pin ticks", 8'hF2, tmr_low);
        timer_clk_sel = 3'h3;
        pulse(1'b0, 16);
        chk("osc ticks", 8'hF4, tmr_low);
        $display("test timer clocks done");
        timer_clk_sel = 3'h0;
        reload = 8'hFE;
        i_peer.bit_clks = 16;
        i_peer.send(8'h11, 1'b1);
        repeat (20) @(negedge clk);
        chk("rx buffer", 8'h00, rx_buf);
        chk("control", 8'h40, ctl);
        wr(0, 8'h10);
        fork
            wr(1, 8'h0F);
            i_peer.send(8'h5A, 1'b1);
        join
        wait_flag(1);
        repeat (40) @(negedge clk);
        chk("rx buffer", 8'h5A, rx_buf);
        chk("control", 8'h57, ctl);
        chk("tx byte", 8'h0F, i_peer.got_byte);
        i_peer.send(8'hC3, 1'b1);
        repeat (20) @(negedge clk);
        chk("rx buffer", 8'h5A, rx_buf);
        chk("control", 8'h57, ctl);
        wr(0, 8'h30);
        i_peer.send(8'h96, 1'b0);
        repeat (20) @(negedge clk);
        chk("rx buffer", 8'h5A, rx_buf);
        chk("control", 8'h70, ctl);
        i_peer.send(8'h96, 1'b1);
        repeat (20) @(negedge clk);
        chk("rx buffer", 8'h96, rx_buf);
        chk("control", 8'h75, ctl);
        $display("test receive done");
        test_done;
    end
    // watchdog well beyond the expected run of about 5000 cycles
    initial begin
        #(20000 * 5);
        failures++;
        $display("watchdog expired");
        test_done;
    end
endmodule
`default_nettype wire
